// *** rtl/uout_cfg.svh ***
// Address map, field layout, codes and reset values of the user output pin block
// Operation
// - Two pins, each with polarity: code 1 active low, code 2 active high.
// - First operand codes: 1-8 bins, 9 out, 10 high, 11 low, 12 pass, 13 fail.
// - Each pin stores operator: 1 first operand only, 2 AND, 3 OR.
// - Each pin stores second operand with the same thirteen codes as the first.
`ifndef UOUT_CFG_SVH
`define UOUT_CFG_SVH

`define UOUT_ADDR_W 8
`define UOUT_PIN0_CFG 8'h00
`define UOUT_PIN_STRIDE 8'h04
`define UOUT_STATUS 8'h08

`define UOUT_POL_POS 0
`define UOUT_OP_POS 4
`define UOUT_FIRST_POS 8
`define UOUT_SECOND_POS 12
`define UOUT_STAT_OUT_POS 16

`define UOUT_POL_LOW 2'h1
`define UOUT_POL_HIGH 2'h2
`define UOUT_OP_FIRST 2'h1
`define UOUT_OP_AND 2'h2
`define UOUT_OP_OR 2'h3
`define UOUT_CODE_MIN 4'h1
`define UOUT_CODE_MAX 4'hd
`define UOUT_JUDGE_W 13

`define UOUT_RST_POL 2'h1
`define UOUT_RST_OP 2'h1
`define UOUT_RST_FIRST 4'hc
`define UOUT_RST_SECOND 4'hd
`define UOUT_RST_PIN 1'b1

`define UOUT_RESP_OKAY 2'h0
`define UOUT_RESP_SLVERR 2'h2

`endif

// *** rtl/uout_pkg.sv ***
// Types shared by the user output pin block
package uout_pkg;
  `include "uout_cfg.svh"
  typedef enum logic [1:0] {
    POL_ACT_LOW = `UOUT_POL_LOW,
    POL_ACT_HIGH = `UOUT_POL_HIGH
  } polarity_t;
  typedef enum logic [1:0] {
    OP_FIRST_ONLY = `UOUT_OP_FIRST,
    OP_AND = `UOUT_OP_AND,
    OP_OR = `UOUT_OP_OR
  } logic_op_t;
  typedef logic [3:0] operand_t;
  typedef logic [`UOUT_JUDGE_W-1:0] judge_t;
endpackage

// *** rtl/pin_if.sv ***
// Configuration and result of one user output pin
`timescale 1ns/1ps
interface pin_if;
  uout_pkg::polarity_t polarity;
  uout_pkg::logic_op_t op;
  uout_pkg::operand_t first_operand_select;
  uout_pkg::operand_t second_operand_select;
  uout_pkg::judge_t judge;
  logic level;
  modport eval (input polarity, input op, input first_operand_select, input second_operand_select,
    input judge, output level);
  modport ctrl (output polarity, output op, output first_operand_select, output second_operand_select,
    output judge, input level);
endinterface

// *** rtl/pin_eval.sv ***
// Combines the selected judgement results of one pin into its pin level
`timescale 1ns/1ps
`include "uout_cfg.svh"
module pin_eval (
  // Pin configuration and judgement
  pin_if.eval pin
);
  import uout_pkg::*;

  // Judgement bit 0 is bin1, codes count from one
  function automatic logic pick(input operand_t code, input judge_t res);
    logic hit;
    hit = 1'b0;
    if (code >= `UOUT_CODE_MIN && code <= `UOUT_CODE_MAX) begin
      hit = res[code - `UOUT_CODE_MIN];
    end
    return hit;
  endfunction

  logic a_bit;
  logic b_bit;
  logic truth;

  always_comb begin
    a_bit = pick(pin.first_operand_select, pin.judge);
    b_bit = pick(pin.second_operand_select, pin.judge);
    unique case (pin.op)
      OP_AND: truth = a_bit & b_bit;
      OP_OR: truth = a_bit | b_bit;
      default: truth = a_bit;
    endcase
    pin.level = (pin.polarity == POL_ACT_HIGH) ? truth : ~truth;
  end
endmodule // pin_eval

// *** rtl/user_output_pin_logic.sv ***
// User output pins with AXI4-Lite configuration registers
`timescale 1ns/1ps
`include "uout_cfg.svh"
module user_output_pin_logic #(
  parameter int NUM_PINS = 2,
  parameter int ADDR_W = `UOUT_ADDR_W
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // Judgement results, same clock domain
  input wire logic JUDGE_STB,
  input wire uout_pkg::judge_t JUDGE_RES,
  // Handler pins
  output logic [NUM_PINS-1:0] USER_OUT,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // AXI4-Lite write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);
  import uout_pkg::*;

  if (NUM_PINS < 1 || NUM_PINS > 2) begin : g_bad_pins
    $error("NUM_PINS must be 1 or 2, the address map holds two pin registers");
  end
  if (ADDR_W < `UOUT_ADDR_W) begin : g_bad_addr
    $error("ADDR_W too narrow for the register map");
  end

  // Pin index of a config register, or -1 when the address is no pin register
  function automatic int pin_of(input logic [ADDR_W-1:0] addr);
    int idx;
    idx = -1;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (addr[`UOUT_ADDR_W-1:0] == `UOUT_PIN0_CFG + 8'(i) * `UOUT_PIN_STRIDE && addr[1:0] == 2'h0) begin
        idx = i;
      end
    end
    return idx;
  endfunction

  function automatic logic code_ok(input operand_t code);
    return code >= `UOUT_CODE_MIN && code <= `UOUT_CODE_MAX;
  endfunction

  polarity_t pol_r [NUM_PINS];
  logic_op_t op_r [NUM_PINS];
  operand_t first_r [NUM_PINS];
  operand_t second_r [NUM_PINS];
  judge_t judge_r;
  logic [NUM_PINS-1:0] level;

  // Write channel state
  logic aw_full_r;
  logic w_full_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_fire;
  logic aw_take;
  logic w_take;
  logic b_done;
  int wr_pin;

  assign aw_take = AWVALID && AWREADY;
  assign w_take = WVALID && WREADY;
  assign wr_fire = aw_full_r && w_full_r && !BVALID;
  assign b_done = BVALID && BREADY;
  assign wr_pin = pin_of(awaddr_r);

  // Address and data are taken in either order; one write in flight at a time
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_full_r <= 1'b1;
        awaddr_r <= AWADDR;
      end else if (wr_fire) begin
        aw_full_r <= 1'b0;
      end
      if (w_take) begin
        w_full_r <= 1'b1;
        wdata_r <= WDATA;
        wstrb_r <= WSTRB;
      end else if (wr_fire) begin
        w_full_r <= 1'b0;
      end
      AWREADY <= !aw_take && !(aw_full_r && !wr_fire) && !(BVALID && !b_done) && !wr_fire;
      WREADY <= !w_take && !(w_full_r && !wr_fire) && !(BVALID && !b_done) && !wr_fire;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      BVALID <= 1'b0;
      BRESP <= `UOUT_RESP_OKAY;
    end else if (wr_fire) begin
      BVALID <= 1'b1;
      BRESP <= (wr_pin < 0) ? `UOUT_RESP_SLVERR : `UOUT_RESP_OKAY;
    end else if (b_done) begin
      BVALID <= 1'b0;
    end
  end

  // Illegal codes leave the field unchanged so the pin never sees an undefined setting
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        pol_r[i] <= polarity_t'(`UOUT_RST_POL);
        op_r[i] <= logic_op_t'(`UOUT_RST_OP);
        first_r[i] <= `UOUT_RST_FIRST;
        second_r[i] <= `UOUT_RST_SECOND;
      end
    end else if (wr_fire && wr_pin >= 0) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (i == wr_pin) begin
          if (wstrb_r[0]) begin
            if (wdata_r[`UOUT_POL_POS +: 2] inside {`UOUT_POL_LOW, `UOUT_POL_HIGH}) begin
              pol_r[i] <= polarity_t'(wdata_r[`UOUT_POL_POS +: 2]);
            end
            if (wdata_r[`UOUT_OP_POS +: 2] inside {`UOUT_OP_FIRST, `UOUT_OP_AND, `UOUT_OP_OR}) begin
              op_r[i] <= logic_op_t'(wdata_r[`UOUT_OP_POS +: 2]);
            end
          end
          if (wstrb_r[1]) begin
            if (code_ok(wdata_r[`UOUT_FIRST_POS +: 4])) begin
              first_r[i] <= wdata_r[`UOUT_FIRST_POS +: 4];
            end
            if (code_ok(wdata_r[`UOUT_SECOND_POS +: 4])) begin
              second_r[i] <= wdata_r[`UOUT_SECOND_POS +: 4];
            end
          end
        end
      end
    end
  end

  // Judgement is held for the status register until the next one; the pins evaluate JUDGE_RES directly
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      judge_r <= '0;
    end else if (JUDGE_STB) begin
      judge_r <= JUDGE_RES;
    end
  end

  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
    pin_if pin ();
    assign pin.polarity = pol_r[g];
    assign pin.op = op_r[g];
    assign pin.first_operand_select = first_r[g];
    assign pin.second_operand_select = second_r[g];
    assign pin.judge = JUDGE_RES;
    assign level[g] = pin.level;
    pin_eval u_eval (
      .pin(pin.eval)
    );

    // Before any judgement each pin rests high, the deasserted level of the reset polarity (active low)
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
        USER_OUT[g] <= `UOUT_RST_PIN;
      end else if (JUDGE_STB) begin
        USER_OUT[g] <= level[g];
      end
    end

    pin_follow_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      JUDGE_STB |=> USER_OUT[g] == $past(level[g]))
      else $error("pin level does not follow judgement");
    pin_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      !JUDGE_STB |=> $stable(USER_OUT[g]))
      else $error("pin changed without judgement");
    pol_legal_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      pol_r[g] inside {POL_ACT_LOW, POL_ACT_HIGH})
      else $error("illegal polarity stored");
    first_legal_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      first_r[g] >= `UOUT_CODE_MIN && first_r[g] <= `UOUT_CODE_MAX)
      else $error("illegal first operand stored");
    op_legal_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      op_r[g] inside {OP_FIRST_ONLY, OP_AND, OP_OR})
      else $error("illegal operator stored");
    second_legal_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      second_r[g] >= `UOUT_CODE_MIN && second_r[g] <= `UOUT_CODE_MAX)
      else $error("illegal second operand stored");
    first_only_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      JUDGE_STB && op_r[g] == OP_FIRST_ONLY && pol_r[g] == POL_ACT_HIGH
      |=> USER_OUT[g] == $past(JUDGE_RES[first_r[g] - `UOUT_CODE_MIN]))
      else $error("first only operator does not pass first operand");
  end

  // Read channel
  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] addr);
    logic [31:0] w;
    int p;
    w = 32'h0;
    p = pin_of(addr);
    if (p >= 0) begin
      w[`UOUT_POL_POS +: 2] = pol_r[p];
      w[`UOUT_OP_POS +: 2] = op_r[p];
      w[`UOUT_FIRST_POS +: 4] = first_r[p];
      w[`UOUT_SECOND_POS +: 4] = second_r[p];
    end else if (addr[`UOUT_ADDR_W-1:0] == `UOUT_STATUS) begin
      w[`UOUT_JUDGE_W-1:0] = judge_r;
      w[`UOUT_STAT_OUT_POS +: NUM_PINS] = USER_OUT;
    end
    return w;
  endfunction

  function automatic logic addr_known(input logic [ADDR_W-1:0] addr);
    return pin_of(addr) >= 0 || addr[`UOUT_ADDR_W-1:0] == `UOUT_STATUS;
  endfunction

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h0;
      RRESP <= `UOUT_RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RDATA <= read_word(ARADDR);
      RRESP <= addr_known(ARADDR) ? `UOUT_RESP_OKAY : `UOUT_RESP_SLVERR;
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
    end else if (!RVALID) begin
      ARREADY <= 1'b1;
    end
  end

  // A second write must not be taken while the response of the first is pending
  bresp_after_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    wr_fire |=> BVALID && !AWREADY && !WREADY)
    else $error("write response missing or new write accepted");
endmodule // user_output_pin_logic

// *** tb/handler_model.sv ***
// Handler model that latches the pins one cycle after each judgement strobe
`timescale 1ns/1ps
module handler_model (
  // Clock and judgement strobe
  input wire logic clk,
  input wire logic judge_stb,
  // Pins from the block and levels latched
  input wire logic [1:0] pins,
  output logic [1:0] seen
);
  logic stb_d_r;
  // Reading a cycle late: a handler only trusts pins once the result has settled
  always_ff @(posedge clk) begin
    stb_d_r <= judge_stb;
    if (stb_d_r) begin
      seen <= pins;
    end
  end
endmodule // handler_model

// *** tb/user_output_pin_logic_tb.sv ***
// Register bus and judgement bench for the user output pin block
`timescale 1ns/1ps
`include "uout_cfg.svh"
module user_output_pin_logic_tb;
  import uout_pkg::*;
  logic clk, rst_b, stb, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  judge_t jres, last_j;
  logic [1:0] uo, seen, bresp, rresp, resp, hold;
  logic [7:0] awaddr, araddr;
  logic [3:0] wstrb;
  logic [31:0] wdata, rdata, rd_val;
  logic [31:0] cfg [2];
  int num_errors = 0;
  int comparisons = 0;
  user_output_pin_logic DUT (.CLK_SYS(clk), .RST_B(rst_b), .JUDGE_STB(stb), .JUDGE_RES(jres), .USER_OUT(uo),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
  handler_model handler (.clk(clk), .judge_stb(stb), .pins(uo), .seen(seen));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task close_out();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task chk(string name, logic [31:0] v, logic [31:0] e);
    comparisons++;
    if (v !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, e, v);
    end
  endtask
  task tick(inout int i);
    @(posedge clk);
    i++;
    if (i > 50) begin
      chk("handshake timeout", 0, 1);
      close_out();
    end
  endtask
  // Payload is dropped at its own handshake edge, so AW and W may be taken apart
  task wr(logic [7:0] a, logic [31:0] d);
    bit aw_ok, w_ok;
    int i;
    aw_ok = 0;
    w_ok = 0;
    i = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      tick(i);
      if (awvalid && awready === 1'b1) begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
    end
    do tick(i); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task rd(logic [7:0] a);
    int i;
    i = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do tick(i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do tick(i); while (rvalid !== 1'b1);
    rd_val = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task judge(judge_t v);
    @(posedge clk);
    stb <= 1'b1;
    jres <= v;
    @(posedge clk);
    stb <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  function logic [1:0] exp_pins(judge_t j);
    logic [1:0] r;
    logic a, b;
    for (int g = 0; g < 2; g++) begin
      a = j[cfg[g][11:8] - 1];
      b = j[cfg[g][15:12] - 1];
      r[g] = (cfg[g][5:4] == 2'h2) ? (a & b) : (cfg[g][5:4] == 2'h3) ? (a | b) : a;
      r[g] = (cfg[g][1:0] == 2'h1) ? ~r[g] : r[g];
    end
    return r;
  endfunction
  initial begin
    {rst_b, stb, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {jres, awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    cfg[0] = 32'h0000dc11;
    cfg[1] = 32'h0000dc11;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    for (int g = 0; g < 2; g++) begin
      rd(8'(g * 4));
      chk("cfg reset", rd_val, cfg[g]);
    end
    judge(13'h0800);
    chk("pins pass", seen, 2'b00);
    judge(13'h1000);
    chk("pins fail", seen, 2'b11);
    $display("test reset and default judge done");
    for (int p = 1; p < 3; p++) begin
      for (int o = 1; o < 4; o++) begin
        for (int c = 1; c < 14; c++) begin
          cfg[0] = {16'h0, 4'(14 - c), 4'(c), 2'h0, 2'(o), 2'h0, 2'(p)};
          cfg[1] = {16'h0, 4'(c), 4'(14 - c), 2'h0, 2'(o), 2'h0, 2'(p)};
          wr(8'h00, cfg[0]);
          wr(8'h04, cfg[1]);
          chk("cfg wr resp", resp, `UOUT_RESP_OKAY);
          rd(8'h04);
          chk("cfg readback", rd_val, cfg[1]);
          chk("cfg rd resp", resp, `UOUT_RESP_OKAY);
          for (int k = 0; k < 4; k++) begin
            last_j = (k[0] ? 13'h1 << (c - 1) : 13'h0) | (k[1] ? 13'h1 << (13 - c) : 13'h0);
            judge(last_j);
            chk("pins", seen, exp_pins(last_j));
          end
        end
      end
    end
    $display("test codes, operators and polarity done");
    wr(8'h00, 32'h0000e000);
    rd(8'h00);
    chk("cfg illegal", rd_val, cfg[0]);
    hold = exp_pins(last_j);
    wr(8'h00, cfg[0] ^ 32'h3);
    chk("pins hold", uo, hold);
    cfg[0] = cfg[0] ^ 32'h3;
    rd(8'h08);
    chk("status", rd_val, {14'h0, hold, 3'h0, last_j});
    judge(last_j);
    chk("pins new polarity", seen, exp_pins(last_j));
    wr(8'h0c, 32'h1);
    chk("unmapped wr resp", resp, `UOUT_RESP_SLVERR);
    rd(8'h0c);
    chk("unmapped rd data", rd_val, 32'h0);
    chk("unmapped rd resp", resp, `UOUT_RESP_SLVERR);
    // Byte lane 1 carries only the operands, lane 0 only polarity and operator
    wstrb <= 4'h2;
    wr(8'h00, 32'h00006522);
    rd(8'h00);
    chk("cfg lane 1", rd_val, {16'h0, 8'h65, cfg[0][7:0]});
    wstrb <= 4'h1;
    wr(8'h00, 32'h00000022);
    rd(8'h00);
    chk("cfg lane 0", rd_val, 32'h00006522);
    wstrb <= 4'hf;
    $display("test illegal, hold and unmapped done");
    close_out();
  end
endmodule // user_output_pin_logic_tb
